// [core/sfdp_spi_slave.sv]
// SPI slave serving the parameter words, status polling and suspend commands.
`timescale 1ns/1ps
module sfdp_spi_slave
  import sfdp_pkg::*;
(
  input  wire logic clk_sys,          // 20 MHz system clock.
  input  wire logic arst_n,           // Asynchronous reset, active low.
  input  wire logic spi_sck,          // SPI clock from host, mode 0.
  input  wire logic spi_cs_n,         // Chip select, active low.
  input  wire logic spi_mosi,         // Serial data in.
  output logic      spi_miso,         // Serial data out.
  output logic      spi_miso_oe_n,    // Output enable, low while driving.
  input  wire logic array_busy,       // Program or erase running.
  output logic      write_in_progress_flag, // Registered busy flag.
  output logic      erase_suspend_req,    // One-cycle pulse.
  output logic      erase_resume_req,     // One-cycle pulse.
  output logic      prog_suspend_req,     // One-cycle pulse.
  output logic      prog_resume_req       // One-cycle pulse.
);
  typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} state_t;

  logic sck_s;
  logic cs_n_s;
  logic mosi_s;

  sync2 u_sck  (.clk_sys(clk_sys), .arst_n(arst_n), .din(spi_sck),
                .dout(sck_s));
  sync2 u_cs   (.clk_sys(clk_sys), .arst_n(arst_n), .din(spi_cs_n),
                .dout(cs_n_s));
  sync2 u_mosi (.clk_sys(clk_sys), .arst_n(arst_n), .din(spi_mosi),
                .dout(mosi_s));

  state_t     state_r,   state_nxt;
  logic       sck_d_r;
  logic [7:0] shift_r,   shift_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [1:0] byte_cnt_r, byte_cnt_nxt;
  logic [7:0] cmd_r,     cmd_nxt;
  logic [7:0] addr_r,    addr_nxt;
  logic [7:0] out_r,     out_nxt;
  logic       miso_r,    miso_nxt;
  logic       oe_n_r,    oe_n_nxt;
  logic       busy_r;
  logic       es_r, er_r, ps_r, pr_r;
  logic       es_nxt, er_nxt, ps_nxt, pr_nxt;
  logic [7:0] rom_data;
  logic       rise;
  logic       fall;
  logic [7:0] byte_in;

  // Host SCK is 400 ns, so eight system cycles per period leave margin.
  assign rise    = sck_s & ~sck_d_r;
  assign fall    = ~sck_s & sck_d_r;
  assign byte_in = {shift_r[6:0], mosi_s};

  table_rom u_rom (.addr(addr_r), .data(rom_data));

  function automatic logic [7:0] status_byte(input logic busy);
    logic [7:0] s;
    s = 8'h00;
    s[STATUS_BUSY_BIT] = busy;
    return s;
  endfunction : status_byte

  always_comb
  begin
    state_nxt    = state_r;
    shift_nxt    = shift_r;
    bit_cnt_nxt  = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    cmd_nxt      = cmd_r;
    addr_nxt     = addr_r;
    out_nxt      = out_r;
    miso_nxt     = miso_r;
    oe_n_nxt     = oe_n_r;
    es_nxt       = 1'b0;
    er_nxt       = 1'b0;
    ps_nxt       = 1'b0;
    pr_nxt       = 1'b0;
    if (cs_n_s)
    begin
      state_nxt    = ST_CMD;
      bit_cnt_nxt  = 3'd0;
      byte_cnt_nxt = 2'd0;
      oe_n_nxt     = 1'b1;
      miso_nxt     = 1'b0;
    end
    else if (rise)
    begin
      shift_nxt   = byte_in;
      bit_cnt_nxt = bit_cnt_r + 3'd1;
      if (bit_cnt_r == 3'd7)
      begin
        case (state_r)
          ST_CMD:
          begin
            cmd_nxt = byte_in;
            case (byte_in)
              CMD_ERASE_SUSPEND: es_nxt = 1'b1;
              CMD_ERASE_RESUME:  er_nxt = 1'b1;
              CMD_PROG_SUSPEND:  ps_nxt = 1'b1;
              CMD_PROG_RESUME:   pr_nxt = 1'b1;
              default: ;
            endcase
            if (byte_in == CMD_READ_STATUS)
            begin
              state_nxt = ST_DATA;
              out_nxt   = status_byte(busy_r);
            end
            else if (byte_in == CMD_READ_TABLE)
              state_nxt = ST_ADDR;
            else
              state_nxt = ST_IGNORE;
          end
          ST_ADDR:
          begin
            byte_cnt_nxt = byte_cnt_r + 2'd1;
            if (byte_cnt_r == 2'd2)
            begin
              addr_nxt  = byte_in;
              state_nxt = ST_DUMMY;
            end
          end
          ST_DUMMY:
          begin
            state_nxt = ST_DATA;
            out_nxt   = rom_data;
            addr_nxt  = addr_r + 8'd1;
          end
          ST_DATA:
          begin
            if (cmd_r == CMD_READ_STATUS)
              out_nxt = status_byte(busy_r);
            else
            begin
              out_nxt  = rom_data;
              addr_nxt = addr_r + 8'd1;
            end
          end
          default: ;
        endcase
      end
    end
    else if (fall && state_r == ST_DATA)
    begin
      // Shift out MSB first on the falling edge; the host samples just before the next fall.
      oe_n_nxt = 1'b0;
      miso_nxt = out_r[3'd7 - bit_cnt_r];
    end
  end

  // First data byte goes out MSB at the fall after the last dummy bit.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r    <= ST_CMD;
      sck_d_r    <= 1'b0;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 3'd0;
      byte_cnt_r <= 2'd0;
      cmd_r      <= 8'h00;
      addr_r     <= 8'h00;
      out_r      <= 8'h00;
      miso_r     <= 1'b0;
      oe_n_r     <= 1'b1;
      busy_r     <= 1'b0;
      es_r       <= 1'b0;
      er_r       <= 1'b0;
      ps_r       <= 1'b0;
      pr_r       <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      sck_d_r    <= sck_s;
      shift_r    <= shift_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      cmd_r      <= cmd_nxt;
      addr_r     <= addr_nxt;
      out_r      <= out_nxt;
      miso_r     <= miso_nxt;
      oe_n_r     <= oe_n_nxt;
      busy_r     <= array_busy;
      es_r       <= es_nxt;
      er_r       <= er_nxt;
      ps_r       <= ps_nxt;
      pr_r       <= pr_nxt;
    end
  end

  // Word fourteen constants are fixed in the package and served by the ROM.
  assign spi_miso               = miso_r;
  assign spi_miso_oe_n          = oe_n_r;
  assign write_in_progress_flag = busy_r;
  assign erase_suspend_req      = es_r;
  assign erase_resume_req       = er_r;
  assign prog_suspend_req       = ps_r;
  assign prog_resume_req        = pr_r;
endmodule : sfdp_spi_slave

// [core/sfdp_pkg.sv]
// Package holding the parameter-table words, command codes and SPI constants.
package sfdp_pkg;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_ERASE_RESUME  = 8'h7A;
  localparam logic [7:0] CMD_PROG_SUSPEND  = 8'h85;
  localparam logic [7:0] CMD_PROG_RESUME   = 8'h8A;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h05;
  localparam logic [7:0] CMD_READ_TABLE    = 8'h5A;
  localparam logic [7:0] NOT_SUPPORTED_CMD = 8'hFF;
  localparam logic       DPD_ABSENT        = 1'b1;
  localparam logic [1:0] DPD_UNITS_64US    = 2'b11;
  localparam logic [4:0] DPD_COUNT         = 5'h1F;
  localparam logic [3:0] RSVD_HI           = 4'hF;
  localparam logic [1:0] POLL_LEGACY       = 2'b01;
  localparam logic [1:0] RSVD_LO           = 2'b11;
  localparam int         STATUS_BUSY_BIT   = 0;
  localparam logic [7:0] WORD13_OFFSET     = 8'h30;
  localparam logic [7:0] WORD14_OFFSET     = 8'h34;
  localparam logic [31:0] WORD13 = {CMD_ERASE_SUSPEND, CMD_ERASE_RESUME,
                                    CMD_PROG_SUSPEND, CMD_PROG_RESUME};
  localparam logic [31:0] WORD14 = {DPD_ABSENT, NOT_SUPPORTED_CMD,
                                    NOT_SUPPORTED_CMD, DPD_UNITS_64US,
                                    DPD_COUNT, RSVD_HI, POLL_LEGACY,
                                    RSVD_LO};
  localparam logic [7:0] TABLE_FILL        = 8'hFF;
endpackage : sfdp_pkg

// [core/sync2.sv]
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module sync2
(
  input  wire logic clk_sys,  // System clock.
  input  wire logic arst_n,   // Asynchronous reset, active low.
  input  wire logic din,      // Asynchronous level.
  output logic      dout      // Synchronised level.
);
  logic meta_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : sync2

// [core/table_rom.sv]
// Parameter-table byte lookup for words thirteen and fourteen.
`timescale 1ns/1ps
module table_rom
  import sfdp_pkg::*;
(
  input  wire logic [7:0] addr,   // Byte offset into the table.
  output logic      [7:0] data    // Byte at that offset.
);
  always_comb
  begin
    data = TABLE_FILL;
    if (addr[7:2] == WORD13_OFFSET[7:2])
      data = WORD13[addr[1:0]*8 +: 8];
    else if (addr[7:2] == WORD14_OFFSET[7:2])
      data = WORD14[addr[1:0]*8 +: 8];
  end
endmodule : table_rom

// [verification/sfdp_spi_slave_assertions.sv]
// Port checker for the parameter-table slave.
`timescale 1ns/1ps
module sfdp_spi_slave_assertions
(
  input wire logic clk_sys,                 // Clock.
  input wire logic arst_n,                  // Reset.
  input wire logic spi_cs_n,                // Select.
  input wire logic spi_miso_oe_n,           // Drive enable.
  input wire logic array_busy,              // Busy in.
  input wire logic write_in_progress_flag,  // Busy flag.
  input wire logic erase_suspend_req,       // Pulse.
  input wire logic erase_resume_req,        // Pulse.
  input wire logic prog_suspend_req,        // Pulse.
  input wire logic prog_resume_req          // Pulse.
);
  wire       busy_seen = write_in_progress_flag;
  wire [3:0] rq  = {erase_suspend_req, erase_resume_req,
                    prog_suspend_req, prog_resume_req};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_busy_flag: assert property
    ($past(arst_n) |-> busy_seen == $past(array_busy))
    else $error("Busy flag does not follow busy input.");
  a_idle_release: assert property (spi_cs_n [*6] |-> spi_miso_oe_n)
    else $error("Output driven while deselected.");
  a_esus_pulse: assert property (rq[3] |=> !rq[3])
    else $error("Erase suspend pulse too long.");
  a_eres_pulse: assert property (rq[2] |=> !rq[2])
    else $error("Erase resume pulse too long.");
  a_psus_pulse: assert property (rq[1] |=> !rq[1])
    else $error("Program suspend pulse too long.");
  a_pres_pulse: assert property (rq[0] |=> !rq[0])
    else $error("Program resume pulse too long.");
  a_one_request: assert property ($onehot0(rq))
    else $error("Two requests at once.");
  a_req_framed: assert property (rq != 4'h0 |-> !spi_cs_n)
    else $error("Request outside a frame.");
  c_esus: cover property (rq[3]);
  c_pres: cover property (rq[0]);
  c_busy_read: cover property (busy_seen && !spi_miso_oe_n);
endmodule : sfdp_spi_slave_assertions
bind sfdp_spi_slave sfdp_spi_slave_assertions chk (.clk_sys, .arst_n,
  .spi_cs_n, .spi_miso_oe_n, .array_busy, .write_in_progress_flag,
  .erase_suspend_req, .erase_resume_req, .prog_suspend_req,
  .prog_resume_req);

// [verification/spi_host_model.sv]
// Host model: mode 0 frames out, reply bits gathered.
`timescale 1ns/1ps
module spi_host_model
(
  input  wire logic clk_sys,        // Clock for the idle pattern.
  input  wire logic spi_miso,       // Data from device.
  input  wire logic spi_miso_oe_n,  // Device drive enable.
  output logic      spi_sck,        // Link clock, still between frames.
  output logic      spi_cs_n,       // Select.
  output logic      spi_mosi        // Data to device.
);
  logic tgl = 1'b0;
  always @(posedge clk_sys) tgl <= ~tgl;
  // A released line toggles so a stale bit cannot pass for data.
  wire line = spi_miso_oe_n ? tgl : spi_miso;
  initial {spi_sck, spi_cs_n, spi_mosi} = 3'b010;
  // Sampling just before the fall keeps clear of the late miso update.
  task automatic frame(input logic [63:0] tx, input int nb,
                       output logic [63:0] rx);
    rx = 64'h0;
    @(posedge clk_sys);
    #7;
    spi_cs_n = 1'b0;
    #200;
    for (int i = 0; i < nb * 8; i++)
    begin
      spi_mosi = tx[63 - i];
      #200 spi_sck = 1'b1;
      #199 rx = {rx[62:0], line};
      #1 spi_sck = 1'b0;
    end
    #200 spi_cs_n = 1'b1;
    #400;
  endtask : frame
endmodule : spi_host_model

// [verification/tb_top.sv]
// Bench: table reads, status polling and command frames.
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        array_busy = 1'b0;
  logic        spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic        busy_flag;
  logic [3:0]  req;
  logic [63:0] rx;
  logic [7:0]  o;
  logic [7:0]  tbl[int];
  logic [7:0]  cmds[5] = '{8'h75, 8'h7A, 8'h85, 8'h8A, 8'h00};
  logic [31:0] w13 = {8'h75, 8'h7A, 8'h85, 8'h8A};
  logic [31:0] w14 = {1'b1, 8'hFF, 8'hFF, 2'b11, 5'h1F, 4'hF, 2'b01, 2'b11};
  int          err_count = 0, cmp_count = 0, cyc = 0, pc[4] = '{0, 0, 0, 0};
  always #25 clk_sys = ~clk_sys;
  sfdp_spi_slave uut (.clk_sys, .arst_n, .spi_sck, .spi_cs_n, .spi_mosi,
    .spi_miso, .spi_miso_oe_n, .array_busy,
    .write_in_progress_flag(busy_flag),
    .erase_suspend_req(req[3]), .erase_resume_req(req[2]),
    .prog_suspend_req(req[1]), .prog_resume_req(req[0]));
  spi_host_model host (.clk_sys, .spi_miso, .spi_miso_oe_n, .spi_sck,
    .spi_cs_n, .spi_mosi);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("errors %0d of %0d checks", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  always @(posedge clk_sys)
  begin
    for (int k = 0; k < 4; k++)
      if (req[k] === 1'b1) pc[k]++;
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(2203));
    for (int b = 0; b < 4; b++)
    begin
      tbl[8'h30 + b] = w13[8 * b +: 8];
      tbl[8'h34 + b] = w14[8 * b +: 8];
    end
    repeat (12) @(posedge clk_sys);
    #7 arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int f = 0; f < 4; f++)
    begin
      o = (f < 3) ? 8'h2F + 8'(3 * f) : 8'($urandom_range(8'h40, 8'h28));
      host.frame({8'h5A, 16'h0, o, 8'h0, 24'h0}, 8, rx);
      for (int b = 0; b < 3; b++)
        chk(rx[23 - 8 * b -: 8], tbl.exists(o + b) ? tbl[o + b] : 8'hFF);
    end
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_sys);
      #7 array_busy = s[0];
      repeat (3) @(posedge clk_sys);
      chk({7'h0, busy_flag}, {7'h0, array_busy});
      host.frame({8'h05, 56'h0}, 3, rx);
      chk(rx[15:8], {7'h0, array_busy});
      chk(rx[7:0], {7'h0, array_busy});
    end
    cmds[4] = 8'($urandom_range(8'hF0, 8'h90));
    for (int k = 0; k < 5; k++)
    begin
      host.frame({cmds[k], 56'h0}, 1, rx);
      for (int j = 0; j < 4; j++)
        chk(8'(pc[j]), (3 - j <= k) ? 8'h01 : 8'h00);
    end
    complete_run();
  end
endmodule : tb_top
